// ===== stp_pkg.sv
// constants shared by the serial test port design
// assumes an apb master on the core clock and an external baud timer
package stp_pkg;

    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [7:0] STP_OFS_KEY0 = 8'h00;
    localparam logic [7:0] STP_OFS_CTRL = 8'h04;
    localparam logic [7:0] STP_OFS_KEY1 = 8'h08;
    localparam logic [7:0] STP_OFS_DAT0 = 8'h0c;
    localparam logic [7:0] STP_OFS_DAT1 = 8'h10;
    localparam logic [7:0] STP_OFS_DAT2 = 8'h14;

    // ************************************************
    // control word fields
    // ************************************************
    localparam int STP_EN_BIT  = 0;
    localparam int STP_RST_BIT = 1;
    localparam int STP_CNT_LSB = 2;
    localparam int STP_CNT_MSB = 4;
    localparam int STP_ST_LSB  = 5;
    localparam int STP_ST_MSB  = 8;
    localparam int STP_RSV_LSB = 9;
    localparam int STP_RSV_MSB = 16;

    // ************************************************
    // key values, reset values, framing
    // ************************************************
    localparam logic [31:0] STP_KEY0_VAL  = 32'h0000_0007;
    localparam logic [31:0] STP_KEY1_VAL  = 32'h0000_00b9;
    localparam logic [4:0]  STP_CTRL_RST  = 5'h00;
    localparam logic [15:0] STP_DAT_RST   = 16'h0000;
    localparam logic [2:0]  STP_CNT_MAX   = 3'h5;
    localparam logic [3:0]  STP_FRAME_TAIL = 4'hb;
    localparam logic        STP_LINE_IDLE = 1'b1;

    typedef enum logic [1:0] {
        STP_KEY_IDLE,
        STP_KEY_ARMED,
        STP_KEY_HELD
    } stp_key_t;

endpackage : stp_pkg

// ===== stp_serial_test_port.sv
// serial test port: keyed control word, three data words, serialiser
// assumes apb on core_clk_in and a one-cycle baud timer overflow pulse
// from logic on the same clock
`timescale 1ns/100ps

// Overview of operation
// - read-only state field nonzero while sending
// - byte-count field plus one gives burst length
// - control reset bit clears port, reads zero
// - control bit zero enables or disables port
// - one bit per baud timer overflow
// - wait until all selected bytes written
// - control reads differ while busy, then revert
// - control write needs key0 7 then key1 b9
// - low byte first, data words ascending
module stp_serial_test_port (
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        ce_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic        baud_tick_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             tx_out
);

    // ************************************************
    // state record
    // ************************************************
    typedef struct packed {
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        stp_pkg::stp_key_t key;
        logic [4:0]       pend;
        logic [4:0]       ctrl;
        logic [2:0][15:0] dat;
        logic [2:0]       dat_wr;
        logic             run;
        logic [2:0]       bidx;
        logic [2:0]       nbyte;
        logic [1:0][7:0]  fifo;
        logic [1:0]       fcnt;
        logic [10:0]      shreg;
        logic [3:0]       bitcnt;
        logic             tx;
    } stp_state_t;

    stp_state_t state_r;
    stp_state_t state_nxt;

    logic [2:0]  cnt;
    logic [3:0]  stat;
    logic [31:0] rdata;
    logic        hit;
    logic        acc;
    logic        wr_take;
    logic [2:0]  need;
    logic        all_wr;
    logic        push;
    logic        pop;
    logic [7:0]  push_byte;
    logic        commit;

    // ************************************************
    // read decode
    // ************************************************
    always_comb begin
        cnt  = state_r.ctrl[stp_pkg::STP_CNT_MSB:stp_pkg::STP_CNT_LSB];
        // state is one more than the number of bytes put on the line
        stat = state_r.run ? (4'(state_r.nbyte) + 4'h1) : 4'h0;
        hit  = 1'b1;
        rdata = 32'h0000_0000;
        unique case (paddr_in)
            stp_pkg::STP_OFS_CTRL: begin
                rdata[stp_pkg::STP_ST_MSB:stp_pkg::STP_ST_LSB] = stat;
                rdata[stp_pkg::STP_CNT_MSB:stp_pkg::STP_CNT_LSB] = cnt;
                rdata[stp_pkg::STP_EN_BIT] =
                    state_r.ctrl[stp_pkg::STP_EN_BIT];
            end
            stp_pkg::STP_OFS_DAT0: begin
                rdata[15:0] = state_r.dat[0];
            end
            stp_pkg::STP_OFS_DAT1: begin
                rdata[15:0] = state_r.dat[1];
            end
            stp_pkg::STP_OFS_DAT2: begin
                rdata[15:0] = state_r.dat[2];
            end
            // key registers are write only and read as zero
            stp_pkg::STP_OFS_KEY0,
            stp_pkg::STP_OFS_KEY1: begin
                rdata = 32'h0000_0000;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        state_nxt = state_r;
        acc       = psel_in & penable_in;
        // writes land at the edge that sees pready high
        wr_take   = acc & state_r.pready & pwrite_in & hit;
        commit    = 1'b0;
        push      = 1'b0;
        pop       = 1'b0;
        push_byte = 8'h00;

        // ************************************************
        // data words needed for the selected count
        // ************************************************
        // counts 6 and 7 ask for every word but never start
        unique case (cnt)
            3'h0,
            3'h1: begin
                need = 3'b001;
            end
            3'h2,
            3'h3: begin
                need = 3'b011;
            end
            3'h4,
            3'h5: begin
                need = 3'b111;
            end
            default: begin
                need = 3'b111;
            end
        endcase
        all_wr = ((state_r.dat_wr & need) == need);

        // ************************************************
        // apb: answer one cycle into the access phase
        // ************************************************
        state_nxt.pready  = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (acc & ~state_r.pready) begin
            state_nxt.pready  = 1'b1;
            state_nxt.pslverr = ~hit;
            state_nxt.prdata  = pwrite_in ? 32'h0000_0000 : rdata;
        end

        // ************************************************
        // burst start
        // ************************************************
        // a burst starts only from idle, so late data cannot restart it
        if (state_r.ctrl[stp_pkg::STP_EN_BIT] & ~state_r.run
            & all_wr & (cnt <= stp_pkg::STP_CNT_MAX)) begin
            state_nxt.run   = 1'b1;
            state_nxt.bidx  = 3'h0;
            state_nxt.nbyte = 3'h0;
        end

        // ************************************************
        // byte feeder into the two-entry buffer
        // ************************************************
        // feeder stalls while both buffer slots hold a byte
        if (state_r.run & (state_r.bidx <= cnt)
            & (state_r.fcnt != 2'h2)) begin
            push = 1'b1;
            push_byte = state_r.bidx[0]
                ? state_r.dat[state_r.bidx[2:1]][15:8]
                : state_r.dat[state_r.bidx[2:1]][7:0];
            state_nxt.bidx = state_r.bidx + 3'h1;
        end

        // ************************************************
        // serialiser, one bit per timer overflow
        // ************************************************
        if (state_r.run & baud_tick_in) begin
            if (state_r.bitcnt != 4'h0) begin
                state_nxt.tx     = state_r.shreg[0];
                state_nxt.shreg  = {1'b1, state_r.shreg[10:1]};
                state_nxt.bitcnt = state_r.bitcnt - 4'h1;
            end else if (state_r.fcnt != 2'h0) begin
                pop = 1'b1;
                state_nxt.tx     = 1'b0;
                state_nxt.shreg  = {2'b11, ^state_r.fifo[0],
                                    state_r.fifo[0]};
                state_nxt.bitcnt = stp_pkg::STP_FRAME_TAIL;
                state_nxt.nbyte  = state_r.nbyte + 3'h1;
            end else if (state_r.bidx > cnt) begin
                // last stop bit has been out for a full bit time
                state_nxt.run    = 1'b0;
                state_nxt.dat_wr = 3'b000;
                state_nxt.nbyte  = 3'h0;
                state_nxt.tx     = stp_pkg::STP_LINE_IDLE;
            end
        end

        // ************************************************
        // buffer bookkeeping
        // ************************************************
        // pop and push in one cycle: the new byte takes the freed slot
        if (pop) begin
            state_nxt.fifo[0] = state_r.fifo[1];
        end
        if (push) begin
            state_nxt.fifo[2'(state_r.fcnt - 2'(pop))] = push_byte;
        end
        state_nxt.fcnt = state_r.fcnt + 2'(push) - 2'(pop);

        // ************************************************
        // keyed control write and data writes
        // ************************************************
        // reads leave the key sequence alone
        if (wr_take) begin
            state_nxt.key = stp_pkg::STP_KEY_IDLE;
            unique case (paddr_in)
                stp_pkg::STP_OFS_KEY0: begin
                    if (pwdata_in == stp_pkg::STP_KEY0_VAL) begin
                        state_nxt.key = stp_pkg::STP_KEY_ARMED;
                    end
                end
                stp_pkg::STP_OFS_CTRL: begin
                    if (state_r.key == stp_pkg::STP_KEY_ARMED) begin
                        state_nxt.key  = stp_pkg::STP_KEY_HELD;
                        state_nxt.pend = pwdata_in[4:0];
                    end
                end
                stp_pkg::STP_OFS_KEY1: begin
                    if ((pwdata_in == stp_pkg::STP_KEY1_VAL)
                        & (state_r.key == stp_pkg::STP_KEY_HELD)) begin
                        commit = 1'b1;
                    end
                end
                stp_pkg::STP_OFS_DAT0: begin
                    state_nxt.dat[0]    = pwdata_in[15:0];
                    state_nxt.dat_wr[0] = 1'b1;
                end
                stp_pkg::STP_OFS_DAT1: begin
                    state_nxt.dat[1]    = pwdata_in[15:0];
                    state_nxt.dat_wr[1] = 1'b1;
                end
                stp_pkg::STP_OFS_DAT2: begin
                    state_nxt.dat[2]    = pwdata_in[15:0];
                    state_nxt.dat_wr[2] = 1'b1;
                end
                default: begin
                    state_nxt.key = stp_pkg::STP_KEY_IDLE;
                end
            endcase
        end

        // ************************************************
        // a new control word aborts any burst in flight
        // ************************************************
        // written flags clear so stale words never restart a burst
        if (commit) begin
            state_nxt.run    = 1'b0;
            state_nxt.fcnt   = 2'h0;
            state_nxt.bitcnt = 4'h0;
            state_nxt.nbyte  = 3'h0;
            state_nxt.bidx   = 3'h0;
            state_nxt.dat_wr = 3'b000;
            state_nxt.tx     = stp_pkg::STP_LINE_IDLE;
            if (state_r.pend[stp_pkg::STP_RST_BIT]) begin
                state_nxt.ctrl = stp_pkg::STP_CTRL_RST;
                state_nxt.dat  = {3{stp_pkg::STP_DAT_RST}};
            end else begin
                state_nxt.ctrl = state_r.pend;
                state_nxt.ctrl[stp_pkg::STP_RST_BIT] = 1'b0;
            end
        end
    end

    // ************************************************
    // state register
    // ************************************************
    // ce_in low freezes every flop, the bus answer too
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // line idles high even while held in reset
            state_r    <= '0;
            state_r.tx <= stp_pkg::STP_LINE_IDLE;
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    // ************************************************
    // outputs, each straight from the state register
    // ************************************************
    assign prdata_out  = state_r.prdata;
    assign pready_out  = state_r.pready;
    assign pslverr_out = state_r.pslverr;
    assign tx_out      = state_r.tx;

endmodule : stp_serial_test_port

// ===== stp_sva_assertions.sv
// checker for the serial test port bus answers and serial line
// assumes ce_in stays high while it watches
`timescale 1ns/100ps
module stp_sva (
    input wire logic        core_clk_in,
    input wire logic        rstn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic        baud_tick_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        tx_out
);
    logic rsp;
    assign rsp = pready_out && !pwrite_in;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // ******
    // assertions
    // ******
    ready_wait_a: assert property ($rose(psel_in && penable_in) |=> pready_out)
        else $error("bus answer late");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("bus answer longer than one cycle");
    bad_addr_a: assert property (pready_out |->
        pslverr_out == (paddr_in[1:0] != 2'h0 || paddr_in > 8'h14))
        else $error("error response wrong");
    ctrl_rsv_a: assert property (rsp && paddr_in == 8'h04 |->
        prdata_out[31:9] == 23'h0 && !prdata_out[1])
        else $error("control reserved bits not zero");
    dat_upper_a: assert property (rsp && !pslverr_out &&
        paddr_in >= 8'h0c |-> prdata_out[31:16] == 16'h0)
        else $error("data word upper half not zero");
    key_read_a: assert property (rsp && (paddr_in == 8'h00 ||
        paddr_in == 8'h08) |-> prdata_out == 32'h0)
        else $error("key register reads nonzero");
    busy_state_a: assert property (rsp && paddr_in == 8'h04 &&
        !tx_out |-> prdata_out[8:5] != 4'h0)
        else $error("state field zero while sending");
    line_step_a: assert property ($changed(tx_out) |->
        $past(baud_tick_in) || $past(baud_tick_in, 2) ||
        $past(pready_out) || $past(pready_out, 2))
        else $error("line moved without a tick");
    cover property (rsp && paddr_in == 8'h04 && !tx_out);
    cover property (pready_out && pslverr_out);
    cover property ($fell(tx_out));
endmodule : stp_sva

bind stp_serial_test_port stp_sva u_sva (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .baud_tick_in(baud_tick_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .tx_out(tx_out));

// ===== stp_rx_model.sv
// receiving test equipment: samples the line at each baud tick
// assumes one bit per tick and a line that idles high
`timescale 1ns/100ps
module stp_rx_model (
    input wire logic core_clk_in,
    input wire logic tick_in,
    input wire logic line_in
);
    logic [11:0] frame;
    int          n = 0;
    int          bad = 0;
    logic [7:0]  got[$];
    // ******
    // frame capture
    // ******
    always @(posedge core_clk_in) begin
        if (tick_in && (n > 0 || line_in === 1'b0)) begin
            frame = {line_in, frame[11:1]};
            n = n + 1;
        end
        if (n == 12) begin
            n = 0;
            if (frame[0] !== 1'b0 || ^frame[9:1] !== 1'b0 ||
                frame[11:10] !== 2'h3)
                bad = bad + 1;
            got.push_back(frame[8:1]);
        end
    end
endmodule : stp_rx_model

// ===== stp_testbench.sv
// self-checking bench for the serial test port over apb
// assumes the receiver model and the checker are compiled with it
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        tick = 1'b0, run = 1'b0, pready, pslverr, tx, err;
    logic [2:0]  div = 3'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, ctrl;
    logic [15:0] words [3] = '{16'h80a5, 16'h01fe, 16'h5a3c};
    int          failures = 0, checks_done = 0, i, c;

    stp_serial_test_port DUT (
        .core_clk_in(clk), .rstn_in(rstn), .ce_in(1'b1), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .baud_tick_in(tick), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .tx_out(tx));
    stp_rx_model rx (.core_clk_in(clk), .tick_in(tick), .line_in(tx));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        div <= div + 3'h1;
        tick <= run && div == 3'h7;
    end
    // ******
    // tasks
    // ******
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t == 20) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc;
        apb(1'b0, stp_pkg::STP_OFS_CTRL, 32'h0);
    endtask : rdc
    task automatic keyed(input logic [31:0] v, input logic [31:0] k1);
        apb(1'b1, stp_pkg::STP_OFS_KEY0, stp_pkg::STP_KEY0_VAL);
        apb(1'b1, stp_pkg::STP_OFS_CTRL, v);
        apb(1'b1, stp_pkg::STP_OFS_KEY1, k1);
    endtask : keyed
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // ******
    // tests
    // ******
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk({31'h0, err}, 32'(i == 6));
            chk(rd, 32'h0);
        end
        apb(1'b1, stp_pkg::STP_OFS_CTRL, 32'h1);
        keyed(32'h1, 32'h0000_00b8);
        rdc;
        chk(rd, 32'h0);
        run <= 1'b1;
        for (c = 0; c < 6; c++) begin
            ctrl = 32'(c << 2) | 32'h1;
            keyed(ctrl, stp_pkg::STP_KEY1_VAL);
            rx.got.delete();
            repeat (40) @(posedge clk);
            rdc;
            chk(rd, ctrl);
            for (i = 0; i <= c / 2; i++)
                apb(1'b1, 8'h0c + 8'(4 * i), {16'h0, words[i]});
            rdc;
            chk({31'h0, rd[8:5] != 4'h0}, 32'h1);
            for (i = 0; i < 400 && rd !== ctrl; i++)
                rdc;
            chk(rd, ctrl);
            chk(32'(rx.got.size()), 32'(c + 1));
            for (i = 0; i <= c; i++)
                chk({24'h0, rx.got[i]},
                    {24'h0, 8'(words[i / 2] >> (8 * i[0]))});
        end
        chk(32'(rx.bad), 32'h0);
        keyed(32'h15, stp_pkg::STP_KEY1_VAL);
        for (i = 0; i < 3; i++)
            apb(1'b1, 8'h0c + 8'(4 * i), {16'h0, words[i]});
        repeat (60) @(posedge clk);
        keyed(32'h0, stp_pkg::STP_KEY1_VAL);
        repeat (3) @(posedge clk);
        chk({31'h0, tx}, 32'h1);
        rdc;
        chk(rd, 32'h0);
        apb(1'b1, stp_pkg::STP_OFS_DAT0, 32'h0000_1234);
        keyed(32'h3, stp_pkg::STP_KEY1_VAL);
        rdc;
        chk(rd, 32'h0);
        apb(1'b0, stp_pkg::STP_OFS_DAT0, 32'h0);
        chk(rd, 32'h0);
        final_report;
    end
    initial begin
        #400000;
        failures++;
        final_report;
    end
endmodule : testbench
